// ### pkg/fiwc_pkg.sv
package fiwc_pkg;
    // ************************************************************
    // sfr map
    // ************************************************************
    localparam logic [7:0]  SFR_SOFTWARE_COMMAND_PORT_ADDR   = 8'h97;
    localparam logic [7:0]  SFR_KEY_ADDR     = 8'hC9;
    localparam logic [7:0]  SFR_MISC2_ADDR   = 8'hF7;
    localparam logic [7:0]  SFR_CFGL_ADDR    = 8'hF6;
    localparam logic [7:0]  SFR_BGAP_ADDR    = 8'hF5;
    localparam logic [7:0]  UNLOCK_KEY       = 8'h65;
    localparam logic [7:0]  FLASH_KEY        = 8'h47;
    localparam logic [7:0]  EEPROM_KEY       = 8'hE2;
    localparam logic [7:0]  MISC2_RESET      = 8'h0E;
    localparam int          KEY_FWE_BIT      = 7;
    localparam int          KEY_TO_BIT       = 6;
    localparam int          KEY_EWE_BIT      = 5;
    localparam int          TSEL_LO          = 1;
    localparam int          TSEL_HI          = 2;
    localparam int          CFGH_LOCK_BIT    = 1;
    // ************************************************************
    // flash map, 16k variant; 8k variant uses its own window
    // ************************************************************
    localparam logic [15:0] LOCK_AREA_END    = 16'h01FF;
    localparam logic [15:0] ALL_AREA_END     = 16'h3EFF;
    localparam logic [15:0] FREE_AREA_BEG    = 16'h3F00;
    localparam logic [15:0] FREE_AREA_END    = 16'h3FF7;
    localparam logic [15:0] CFG_AREA_END     = 16'h3FFE;
    localparam logic [15:0] CFG_HIGH_ADDR    = 16'h3FFF;
    localparam logic [15:0] CFG_LOW_ADDR     = 16'h3FFD;
    localparam logic [15:0] CFG_BGAP_ADDR    = 16'h3FFB;
    localparam logic [15:0] IAP16_BEG        = 16'h3000;
    localparam logic [15:0] IAP16_END        = 16'h3FEF;
    localparam logic [15:0] IAP8_BEG         = 16'h1000;
    localparam logic [15:0] IAP8_END         = 16'h1FEF;
    localparam logic [15:0] EEPROM_BEG       = 16'hEE00;
    localparam logic [15:0] EEPROM_END       = 16'hEEFE;
    // ************************************************************
    // timing, clk_sys at 250 MHz
    // ************************************************************
    localparam int          CLK_MHZ          = 250;
    localparam int          WRITE_US_LOWV    = 2000;
    localparam int          WRITE_US_HIGHV   = 1000;
    localparam int          TO1_US10         = 9;
    localparam int          TO2_US10         = 36;
    localparam int          TO3_US10         = 72;
    localparam int          WRITE_CYC_LOWV   = WRITE_US_LOWV * CLK_MHZ;
    localparam int          WRITE_CYC_HIGHV  = WRITE_US_HIGHV * CLK_MHZ;
    localparam int          TO1_CYC          = TO1_US10 * CLK_MHZ * 100;
    localparam int          TO2_CYC          = TO2_US10 * CLK_MHZ * 100;
    localparam int          TO3_CYC          = TO3_US10 * CLK_MHZ * 100;
    localparam int          CNT_W            = 21;
    localparam int          CFG_BYTES        = 3;

    typedef enum logic [1:0]
    {
        FIWC_IDLE = 2'b00,
        FIWC_BUSY = 2'b01,
        FIWC_BOOT = 2'b10
    } fiwc_state_e;
endpackage : fiwc_pkg

// ### hw/fiwc_access_check.sv
`timescale 1ns/1ps
`default_nettype none
module fiwc_access_check
    import fiwc_pkg::*;
(
    // request
    input  wire logic [15:0] addr,
    input  wire logic        read_lock,
    input  wire logic        unlock,
    // verdict
    output logic             wr_ok,
    output logic             rd_ok
);
    // ************************************************************
    // region decode
    // ************************************************************
    always_comb
    begin
        wr_ok = 1'b0;
        rd_ok = (addr <= CFG_AREA_END);
        if (addr <= LOCK_AREA_END)
        begin
            rd_ok = !read_lock;
            wr_ok = !read_lock && unlock;
        end
        else if (addr <= ALL_AREA_END)
            wr_ok = unlock;
        else if (addr >= FREE_AREA_BEG && addr <= FREE_AREA_END)
            wr_ok = 1'b1;
        else if (addr == CFG_HIGH_ADDR)
            wr_ok = 1'b0;
        else if (addr <= CFG_AREA_END)
            wr_ok = unlock;
    end
endmodule : fiwc_access_check
`default_nettype wire

// ### hw/fiwc_timer.sv
`timescale 1ns/1ps
`default_nettype none
module fiwc_timer
    import fiwc_pkg::*;
(
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    input  wire logic             ce,
    // control
    input  wire logic             start,
    input  wire logic             stop,
    input  wire logic [CNT_W-1:0] limit,
    // status
    output logic                  done
);
    typedef struct packed
    {
        logic             run;
        logic [CNT_W-1:0] cnt;
        logic             done;
    } fiwc_tmr_s;

    fiwc_tmr_s tmr_q;
    fiwc_tmr_s tmr_d;

    // ************************************************************
    // one-shot down counter; done is a one-cycle pulse
    // ************************************************************
    always_comb
    begin
        tmr_d = tmr_q;
        tmr_d.done = 1'b0;
        if (start)
        begin
            tmr_d.run = 1'b1;
            tmr_d.cnt = limit;
        end
        else if (stop)
            tmr_d.run = 1'b0;
        else if (tmr_q.run)
        begin
            if (tmr_q.cnt <= CNT_W'(1))
            begin
                tmr_d.run = 1'b0;
                tmr_d.done = 1'b1;
            end
            else
                tmr_d.cnt = tmr_q.cnt - CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            tmr_q <= '0;
        else if (ce)
            tmr_q <= tmr_d;
    end

    assign done = tmr_q.done;
endmodule : fiwc_timer
`default_nettype wire

// ### hw/fiwc_top.sv
// Notes on behaviour
// - top eight flash bytes hold configuration; three of them are loaded into registers at power-on.
// - application-write region 3000h-3FEFh on 16K, 1000h-1FEFh on 8K.
// - writes are single bytes with no page erase beforehand.
// - after reset only the 248-byte free region is writable.
// - lowest 512 bytes: lock blocks reads and writes, else writes need unlock.
// - 0200h-3EFFh writable only while whole-array unlock is set.
// - 65h to command port sets unlock; any other value clears it.
// - command port bit 0 reads back the unlock flag.
// - 3F00h-3FF7h always writable and readable.
// - last byte never writable; config low and bandgap need unlock.
// - power-on copies config low to F6h, bandgap to F5h; software overrides.
// - write is data store with pointer address, accepted only when enabled.
// - cpu waits about 2 ms or 1 ms during a byte write.
// - code reads served 0000h-3FFEh with no extra wait.
// - 47h sets flash enable, E2h eeprom enable, other clears both.
// - key register bit 7 reads flash enable.
// - timeout flag at key bit 6, set on timeout, cleared with enable.
// - timeout select 00 off, 01 0.9 ms, 10 3.6 ms, 11 7.2 ms.
// - eeprom writes share the watchdog and its flag.
`timescale 1ns/1ps
`default_nettype none
module fiwc_top
    import fiwc_pkg::*;
#(
    parameter int WRITE_CYCLES = WRITE_CYC_LOWV,
    parameter int TO1_CYCLES   = TO1_CYC,
    parameter int TO2_CYCLES   = TO2_CYC,
    parameter int TO3_CYCLES   = TO3_CYC
)
(
    // clock, reset, enable
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic        por_event,
    input  wire logic        small_variant,
    // sfr bus from cpu
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    // data store from cpu
    input  wire logic        xdata_wr,
    input  wire logic [15:0] xdata_addr,
    input  wire logic [7:0]  xdata_wdata,
    output logic             cpu_wait,
    // code read from cpu
    input  wire logic        code_rd,
    input  wire logic [15:0] code_addr,
    output logic             code_ok,
    // flash macro
    output logic             fl_wr,
    output logic      [15:0] fl_addr,
    output logic      [7:0]  fl_wdata,
    output logic             fl_rd,
    output logic      [15:0] fl_raddr,
    input  wire logic [7:0]  fl_rdata,
    input  wire logic        fl_done,
    // eeprom macro
    output logic             ee_wr,
    input  wire logic        ee_done,
    // configuration out
    output logic      [7:0]  cfg_low,
    output logic      [7:0]  cfg_bgap,
    output logic      [7:0]  misc2,
    output logic             iap_window
);
    typedef struct packed
    {
        fiwc_state_e       st;
        logic [1:0]        boot_idx;
        logic              boot_rd;
        logic              lock;
        logic              unlock;
        logic              fwe;
        logic              ewe;
        logic              tflag;
        logic [7:0]        cfgl;
        logic [7:0]        bgap;
        logic [7:0]        misc2;
        logic [7:0]        rdata;
        logic              wait_c;
        logic              fl_wr;
        logic [15:0]       fl_addr;
        logic [7:0]        fl_wdata;
        logic              fl_rd;
        logic [15:0]       fl_raddr;
        logic              ee_wr;
        logic              code_ok;
        logic              iapw;
    } fiwc_top_s;

    fiwc_top_s         s_q;
    fiwc_top_s         s_d;
    logic              wr_ok;
    logic              rd_ok;
    logic              busy_start;
    logic              wd_start;
    logic              wd_done;
    logic              wr_done;
    logic [CNT_W-1:0]  wd_limit;
    logic [1:0]        tsel;
    logic              is_ee;
    logic [15:0]       boot_addr;

    fiwc_access_check u_check
    (
        .addr      (xdata_addr),
        .read_lock (s_q.lock),
        .unlock    (s_q.unlock),
        .wr_ok     (wr_ok),
        .rd_ok     ()
    );

    fiwc_access_check u_rcheck
    (
        .addr      (code_addr),
        .read_lock (s_q.lock),
        .unlock    (s_q.unlock),
        .wr_ok     (),
        .rd_ok     (rd_ok)
    );

    // ************************************************************
    // watchdog and write completion
    // ************************************************************
    assign tsel = s_q.misc2[TSEL_HI:TSEL_LO];

    always_comb
    begin
        case (tsel)
            2'b01:   wd_limit = CNT_W'(TO1_CYCLES);
            2'b10:   wd_limit = CNT_W'(TO2_CYCLES);
            2'b11:   wd_limit = CNT_W'(TO3_CYCLES);
            default: wd_limit = '0;
        endcase
    end

    assign is_ee = xdata_addr >= EEPROM_BEG && xdata_addr <= EEPROM_END;
    assign wd_start = busy_start && (tsel != 2'b00);

    fiwc_timer u_wdog
    (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .ce      (ce),
        .start   (wd_start),
        .stop    (wr_done),
        .limit   (wd_limit),
        .done    (wd_done)
    );

    // write ends on macro done; the macro sets the 1-2 ms itself
    assign wr_done = s_q.st == FIWC_BUSY && (fl_done || ee_done);

    always_comb
    begin
        case (s_q.boot_idx)
            2'd0:    boot_addr = CFG_HIGH_ADDR;
            2'd1:    boot_addr = CFG_LOW_ADDR;
            default: boot_addr = CFG_BGAP_ADDR;
        endcase
    end

    // ************************************************************
    // main sequencer
    // ************************************************************
    always_comb
    begin
        s_d = s_q;
        busy_start = 1'b0;
        s_d.fl_wr = 1'b0;
        s_d.ee_wr = 1'b0;
        s_d.fl_rd = 1'b0;
        s_d.code_ok = 1'b0;
        // 8k part keeps the 16k protection map; only the window moves
        s_d.iapw = small_variant ?
            (xdata_addr >= IAP8_BEG && xdata_addr <= IAP8_END) :
            (xdata_addr >= IAP16_BEG && xdata_addr <= IAP16_END);

        // ****************************************
        // sfr writes; a wrong key clears, never holds
        // ****************************************
        if (sfr_wr && sfr_addr == SFR_SOFTWARE_COMMAND_PORT_ADDR)
            s_d.unlock = sfr_wdata == UNLOCK_KEY;
        if (sfr_wr && sfr_addr == SFR_KEY_ADDR)
        begin
            s_d.fwe = sfr_wdata == FLASH_KEY;
            s_d.ewe = sfr_wdata == EEPROM_KEY;
        end
        if (sfr_wr && sfr_addr == SFR_MISC2_ADDR)
            s_d.misc2 = sfr_wdata;
        if (sfr_wr && sfr_addr == SFR_CFGL_ADDR)
            s_d.cfgl = sfr_wdata;
        if (sfr_wr && sfr_addr == SFR_BGAP_ADDR)
            s_d.bgap = sfr_wdata;
        if (!s_d.fwe && !s_d.ewe)
            s_d.tflag = 1'b0;
        if (wd_done)
            s_d.tflag = 1'b1;

        // ****************************************
        // sequencer; writes arriving while busy are dropped
        // ****************************************
        case (s_q.st)
            FIWC_BOOT:
            begin
                if (!s_q.boot_rd)
                begin
                    s_d.fl_rd = 1'b1;
                    s_d.fl_raddr = boot_addr;
                    s_d.boot_rd = 1'b1;
                end
                else
                begin
                    s_d.boot_rd = 1'b0;
                    case (s_q.boot_idx)
                        2'd0:    s_d.lock = fl_rdata[CFGH_LOCK_BIT];
                        2'd1:    s_d.cfgl = fl_rdata;
                        default: s_d.bgap = fl_rdata;
                    endcase
                    if (s_q.boot_idx == 2'(CFG_BYTES - 1))
                    begin
                        s_d.st = FIWC_IDLE;
                        s_d.wait_c = 1'b0;
                        s_d.boot_idx = '0;
                    end
                    else
                        s_d.boot_idx = s_q.boot_idx + 2'd1;
                end
            end
            FIWC_BUSY:
            begin
                if (wr_done || wd_done)
                begin
                    s_d.st = FIWC_IDLE;
                    s_d.wait_c = 1'b0;
                end
            end
            FIWC_IDLE:
            begin
                if (xdata_wr && is_ee && s_q.ewe)
                begin
                    s_d.ee_wr = 1'b1;
                    s_d.fl_addr = xdata_addr;
                    s_d.fl_wdata = xdata_wdata;
                    s_d.st = FIWC_BUSY;
                    s_d.wait_c = 1'b1;
                    busy_start = 1'b1;
                end
                else if (xdata_wr && s_q.fwe && wr_ok)
                begin
                    s_d.fl_wr = 1'b1;
                    s_d.fl_addr = xdata_addr;
                    s_d.fl_wdata = xdata_wdata;
                    s_d.st = FIWC_BUSY;
                    s_d.wait_c = 1'b1;
                    busy_start = 1'b1;
                end
                if (code_rd)
                begin
                    s_d.fl_rd = 1'b1;
                    s_d.fl_raddr = code_addr;
                    s_d.code_ok = rd_ok;
                end
            end
            default:
                s_d.st = FIWC_IDLE;
        endcase

        // ****************************************
        // power-on load overrides any state
        // ****************************************
        if (por_event)
        begin
            s_d.st = FIWC_BOOT;
            s_d.boot_idx = '0;
            s_d.boot_rd = 1'b0;
            s_d.wait_c = 1'b1;
        end

        // ****************************************
        // read-back; zero unless read so stale data never shows
        // ****************************************
        s_d.rdata = 8'h00;
        if (sfr_rd)
        begin
            case (sfr_addr)
                SFR_SOFTWARE_COMMAND_PORT_ADDR: s_d.rdata[0] = s_q.unlock;
                SFR_KEY_ADDR:
                begin
                    s_d.rdata[KEY_FWE_BIT] = s_q.fwe;
                    s_d.rdata[KEY_TO_BIT]  = s_q.tflag;
                    s_d.rdata[KEY_EWE_BIT] = s_q.ewe;
                end
                SFR_MISC2_ADDR: s_d.rdata = s_q.misc2;
                SFR_CFGL_ADDR:  s_d.rdata = s_q.cfgl;
                SFR_BGAP_ADDR:  s_d.rdata = s_q.bgap;
                default:        s_d.rdata = 8'h00;
            endcase
        end
    end

    // ************************************************************
    // state register; unlock and enables clear on every reset
    // ************************************************************
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            s_q <= '0;
            s_q.st <= FIWC_IDLE;
            s_q.misc2 <= MISC2_RESET;
        end
        else if (ce)
            s_q <= s_d;
    end

    // ************************************************************
    // outputs, all from flip-flops
    // ************************************************************
    assign sfr_rdata  = s_q.rdata;
    assign cpu_wait   = s_q.wait_c;
    assign code_ok    = s_q.code_ok;
    assign fl_wr      = s_q.fl_wr;
    assign fl_addr    = s_q.fl_addr;
    assign fl_wdata   = s_q.fl_wdata;
    assign fl_rd      = s_q.fl_rd;
    assign fl_raddr   = s_q.fl_raddr;
    assign ee_wr      = s_q.ee_wr;
    assign cfg_low    = s_q.cfgl;
    assign cfg_bgap   = s_q.bgap;
    assign misc2      = s_q.misc2;
    assign iap_window = s_q.iapw;
endmodule : fiwc_top
`default_nettype wire

// ### tb/fiwc_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module fiwc_top_chk
    import fiwc_pkg::*;
(
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rstn,
    input wire logic        small_variant,
    // cpu side
    input wire logic        sfr_rd,
    input wire logic [7:0]  sfr_rdata,
    input wire logic        xdata_wr,
    input wire logic [15:0] xdata_addr,
    input wire logic [7:0]  xdata_wdata,
    input wire logic        cpu_wait,
    input wire logic        code_rd,
    input wire logic [15:0] code_addr,
    input wire logic        code_ok,
    // macro side
    input wire logic        fl_wr,
    input wire logic [15:0] fl_addr,
    input wire logic [7:0]  fl_wdata,
    input wire logic        fl_rd,
    input wire logic        fl_done,
    input wire logic        ee_wr,
    input wire logic        iap_window
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    // ********
    // properties
    // ********
    property p_wr_wait;
        fl_wr |-> cpu_wait;
    endproperty
    property p_wr_src;
        fl_wr |-> $past(xdata_wr) && fl_addr == $past(xdata_addr)
            && fl_wdata == $past(xdata_wdata);
    endproperty
    property p_code;
        code_ok |-> fl_rd && $past(code_rd) && $past(code_addr) <= 16'h3FFE;
    endproperty
    property p_cfgh;
        fl_wr |-> fl_addr != CFG_HIGH_ADDR;
    endproperty
    property p_release;
        fl_done && cpu_wait |=> !cpu_wait;
    endproperty
    property p_ee_wait;
        ee_wr |-> cpu_wait ##1 cpu_wait;
    endproperty
    property p_busy;
        fl_wr |-> !$past(cpu_wait);
    endproperty
    property p_rd_idle;
        !sfr_rd |=> sfr_rdata == 8'h00;
    endproperty
    property p_win;
        xdata_wr && !cpu_wait |=> iap_window == ($past(small_variant)
            ? $past(xdata_addr) inside {[IAP8_BEG:IAP8_END]}
            : $past(xdata_addr) inside {[IAP16_BEG:IAP16_END]});
    endproperty
    a_wr_wait:  assert property (p_wr_wait) else $error("no wait");
    a_wr_src:   assert property (p_wr_src) else $error("bad src");
    a_code:     assert property (p_code) else $error("bad read");
    a_cfgh:     assert property (p_cfgh) else $error("cfg hi");
    a_release:  assert property (p_release) else $error("stuck");
    a_ee_wait:  assert property (p_ee_wait) else $error("ee wait");
    a_busy:     assert property (p_busy) else $error("busy wr");
    a_rd_idle:  assert property (p_rd_idle) else $error("rdata");
    a_win:      assert property (p_win) else $error("window");
    c_wr:       cover property (fl_wr ##[1:40] fl_done);
    c_ee:       cover property (ee_wr);
    c_code:     cover property (code_ok);
endmodule : fiwc_top_chk

bind fiwc_top fiwc_top_chk fiwc_top_chk_i (.clk_sys, .rstn,
    .small_variant, .sfr_rd, .sfr_rdata, .xdata_wr, .xdata_addr,
    .xdata_wdata, .cpu_wait, .code_rd, .code_addr, .code_ok, .fl_wr,
    .fl_addr, .fl_wdata, .fl_rd, .fl_done, .ee_wr, .iap_window);
`default_nettype wire

// ### tb/fiwc_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fiwc_flash_model
#(
    parameter int DLY = 10
)
(
    // clock and fault
    input  wire logic        clk_sys,
    input  wire logic        hang,
    // write path
    input  wire logic        fl_wr,
    input  wire logic        ee_wr,
    input  wire logic [15:0] fl_addr,
    input  wire logic [7:0]  fl_wdata,
    output logic             fl_done,
    output logic             ee_done,
    // read path
    input  wire logic        fl_rd,
    input  wire logic [15:0] fl_raddr,
    output logic      [7:0]  fl_rdata
);
    logic [7:0] mem [0:65535];
    int         cnt = 0;
    logic       is_ee = 1'b0;
    initial
    begin
        for (int i = 0; i < 65536; i++)
            mem[i] = 8'hFF;
        fl_done = 1'b0;
        ee_done = 1'b0;
    end
    // data valid only while fl_rd stands; inverted otherwise
    assign fl_rdata = fl_rd ? mem[fl_raddr] : ~mem[fl_raddr];
    // byte lands alone, no erase step
    // done only after busy time; hang never answers
    always @(posedge clk_sys)
    begin
        fl_done <= 1'b0;
        ee_done <= 1'b0;
        if ((fl_wr || ee_wr) && !hang)
        begin
            mem[fl_addr] <= fl_wdata;
            cnt <= DLY;
            is_ee <= ee_wr;
        end
        else if (hang)
            cnt <= 0;
        else if (cnt > 0)
        begin
            cnt <= cnt - 1;
            fl_done <= cnt == 1 && !is_ee;
            ee_done <= cnt == 1 && is_ee;
        end
    end
endmodule : fiwc_flash_model
`default_nettype wire

// ### tb/fiwc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fiwc_top_bench;
    import fiwc_pkg::*;
    localparam int DLY = 10;
    localparam int TO1 = 20, TO2 = 40, TO3 = 80;
    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    logic        por_event = 1'b0;
    logic        small_variant = 1'b0;
    logic        sfr_wr = 1'b0;
    logic        sfr_rd = 1'b0;
    logic [7:0]  sfr_addr = 8'h00;
    logic [7:0]  sfr_wdata = 8'h00;
    logic        xdata_wr = 1'b0;
    logic [15:0] xdata_addr = 16'h0000;
    logic [7:0]  xdata_wdata = 8'h00;
    logic        code_rd = 1'b0;
    logic [15:0] code_addr = 16'h0000;
    logic        hang = 1'b0;
    logic [7:0]  sfr_rdata, fl_wdata, fl_rdata, cfg_low, cfg_bgap, misc2;
    logic [15:0] fl_addr, fl_raddr;
    logic        cpu_wait, code_ok, fl_wr, fl_rd, fl_done, ee_wr, ee_done;
    logic        iap_window;
    int          n_errors = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    initial
        forever #2 clk_sys = ~clk_sys;
    fiwc_top #(.TO1_CYCLES(TO1), .TO2_CYCLES(TO2), .TO3_CYCLES(TO3))
    fiwc_top_i (.clk_sys, .rstn, .ce(1'b1), .por_event, .small_variant,
        .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata, .xdata_wr,
        .xdata_addr, .xdata_wdata, .cpu_wait, .code_rd, .code_addr,
        .code_ok, .fl_wr, .fl_addr, .fl_wdata, .fl_rd, .fl_raddr,
        .fl_rdata, .fl_done, .ee_wr, .ee_done, .cfg_low, .cfg_bgap,
        .misc2, .iap_window);
    fiwc_flash_model #(.DLY(DLY)) fiwc_flash_model_i (.clk_sys, .hang,
        .fl_wr, .ee_wr, .fl_addr, .fl_wdata, .fl_done, .ee_done, .fl_rd,
        .fl_raddr, .fl_rdata);
    // ********
    // tasks
    // ********
    task automatic test_done;
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                       input string nm);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic sw(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        sfr_wr = 1'b1;
        sfr_addr = a;
        sfr_wdata = d;
        @(negedge clk_sys);
        sfr_wr = 1'b0;
    endtask : sw
    task automatic sr(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        sfr_rd = 1'b1;
        sfr_addr = a;
        @(negedge clk_sys);
        sfr_rd = 1'b0;
        chk(sfr_rdata, e, "sfr");
    endtask : sr
    // data fetch goes by code reads only
    task automatic cr(input logic [15:0] a, input logic e);
        @(negedge clk_sys);
        code_rd = 1'b1;
        code_addr = a;
        @(negedge clk_sys);
        code_rd = 1'b0;
        chk(code_ok, e, "code ok");
    endtask : cr
    task automatic xw(input logic [15:0] a, input logic [7:0] d,
                      input logic acc, input int lim);
        int n;
        n = 0;
        @(negedge clk_sys);
        xdata_wr = 1'b1;
        xdata_addr = a;
        xdata_wdata = d;
        @(negedge clk_sys);
        xdata_wr = 1'b0;
        chk(fl_wr | ee_wr, acc, "accept");
        chk(cpu_wait, acc, "wait");
        while (cpu_wait === 1'b1 && n < 1000)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (acc)
            chk(n >= lim - 1 && n <= lim + 3, 1'b1, "wait len");
        if (acc && !hang)
            chk(fiwc_flash_model_i.mem[a], d, "flash");
    endtask : xw
    task automatic boot(input logic [7:0] hi);
        int n;
        n = 0;
        fiwc_flash_model_i.mem[CFG_HIGH_ADDR] = hi;
        @(negedge clk_sys);
        por_event = 1'b1;
        @(negedge clk_sys);
        por_event = 1'b0;
        chk(cpu_wait, 1'b1, "boot wait");
        while (cpu_wait === 1'b1 && n < 100)
        begin
            @(negedge clk_sys);
            n++;
        end
        chk(cfg_low, 8'hA5, "cfg low");
        chk(cfg_bgap, 8'h3C, "cfg bgap");
    endtask : boot
    // ********
    // sequence
    // ********
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_errors++;
            test_done();
        end
    end
    initial
    begin
        fiwc_flash_model_i.mem[CFG_LOW_ADDR] = 8'hA5;
        fiwc_flash_model_i.mem[CFG_BGAP_ADDR] = 8'h3C;
        repeat (5) @(negedge clk_sys);
        rstn = 1'b1;
        sr(SFR_MISC2_ADDR, MISC2_RESET);
        sr(SFR_KEY_ADDR, 8'h00);
        sr(SFR_SOFTWARE_COMMAND_PORT_ADDR, 8'h00);
        sr(8'h80, 8'h00);
        boot(8'h02);
        sr(SFR_CFGL_ADDR, 8'hA5);
        sr(SFR_BGAP_ADDR, 8'h3C);
        sw(SFR_CFGL_ADDR, 8'h5A);
        chk(cfg_low, 8'h5A, "cfg sw");
        cr(16'h0100, 1'b0);
        cr(16'h0200, 1'b1);
        cr(16'h3FFE, 1'b1);
        cr(16'h3F00, 1'b1);
        xw(16'h3F00, 8'h11, 1'b0, 0);
        chk(iap_window, 1'b1, "win16");
        sw(SFR_KEY_ADDR, FLASH_KEY);
        sr(SFR_KEY_ADDR, 8'h80);
        xw(16'h3F00, 8'h5A, 1'b1, DLY);
        xw(16'h3F00, 8'hC3, 1'b1, DLY);
        xw(16'h3FF7, 8'h01, 1'b1, DLY);
        xw(16'h3EFF, 8'h02, 1'b0, 0);
        xw(16'h3FFD, 8'h03, 1'b0, 0);
        sw(SFR_SOFTWARE_COMMAND_PORT_ADDR, UNLOCK_KEY);
        sr(SFR_SOFTWARE_COMMAND_PORT_ADDR, 8'h01);
        xw(16'h3EFF, 8'h04, 1'b1, DLY);
        xw(16'h0200, 8'h05, 1'b1, DLY);
        xw(16'h3FFD, 8'hA5, 1'b1, DLY);
        xw(16'h3FFB, 8'h3C, 1'b1, DLY);
        xw(16'h3FFF, 8'h06, 1'b0, 0);
        xw(16'h0100, 8'h07, 1'b0, 0);
        small_variant = 1'b1;
        xw(16'h1000, 8'h08, 1'b1, DLY);
        chk(iap_window, 1'b1, "win8");
        small_variant = 1'b0;
        sw(SFR_SOFTWARE_COMMAND_PORT_ADDR, 8'h12);
        sr(SFR_SOFTWARE_COMMAND_PORT_ADDR, 8'h00);
        hang = 1'b1;
        for (int m = 1; m < 4; m++)
        begin
            sw(SFR_MISC2_ADDR, 8'h08 | 8'(m << 1));
            chk(misc2, 8'h08 | 8'(m << 1), "misc2");
            xw(16'h3F00, 8'h77, 1'b1, TO1 << (m - 1));
            sr(SFR_KEY_ADDR, 8'hC0);
        end
        sw(SFR_KEY_ADDR, 8'h00);
        sr(SFR_KEY_ADDR, 8'h00);
        sw(SFR_KEY_ADDR, EEPROM_KEY);
        sr(SFR_KEY_ADDR, 8'h20);
        xw(EEPROM_BEG, 8'h99, 1'b1, TO3);
        sr(SFR_KEY_ADDR, 8'h60);
        hang = 1'b0;
        xw(EEPROM_BEG, 8'h9A, 1'b1, DLY);
        sw(SFR_KEY_ADDR, 8'h12);
        sr(SFR_KEY_ADDR, 8'h00);
        boot(8'h00);
        cr(16'h0100, 1'b1);
        sw(SFR_KEY_ADDR, FLASH_KEY);
        xw(16'h0100, 8'h0A, 1'b0, 0);
        sw(SFR_SOFTWARE_COMMAND_PORT_ADDR, UNLOCK_KEY);
        xw(16'h0100, 8'h0B, 1'b1, DLY);
        test_done();
    end
endmodule : fiwc_top_bench
`default_nettype wire
